/* verilog/i2c_seq_consts.svh */
// register offsets, bit positions and reset values for the i2c condition sequencer
// assumes an 8-bit register port and a 25 MHz device clock
`ifndef I2C_SEQ_CONSTS_SVH
`define I2C_SEQ_CONSTS_SVH

// register offsets on the plain register port
`define OFS_SERIAL_CONTROL     4'h0
`define OFS_SERIAL_CONTROL_TWO 4'h1
`define OFS_BAUD_RELOAD_VALUE  4'h2
`define OFS_SERIAL_STATUS_REG  4'h3
`define OFS_EVENT_REG          4'h4
`define OFS_SERIAL_BUFFER      4'h5

// serial_control bits
`define BIT_MODULE_ENABLE      0

// serial_control_two bits
`define BIT_REPEATED_START_REQ 1
`define BIT_STOP_REQ           2
`define CTL2_LOCKED_BITS       5

// serial_status_reg bits
`define BIT_START_SEEN         3
`define BIT_STOP_SEEN          4

// event register bits, write one to clear
`define BIT_SERIAL_EVENT       0
`define BIT_WRITE_COLLISION    1
`define BIT_BUS_COLLISION      2

// reset values
`define RST_CONTROL            8'h00
`define RST_MODULE_ENABLE      1'b0
`define RST_CONTROL_TWO        8'h00
`define RST_BAUD_RELOAD        7'h00
`define RST_BUFFER             8'h00

`endif

/* verilog/i2c_seq_pkg.sv */
// types shared by the i2c condition sequencer
// assumes i2c_seq_consts.svh supplies offsets and bit positions
package i2c_seq_pkg;

   typedef enum logic [3:0] {
      st_idle,
      st_rs_scl_low,
      st_rs_sda_high,
      st_rs_scl_rel,
      st_rs_both_high,
      st_rs_sda_low,
      st_p_sda_low,
      st_p_count,
      st_p_scl_high,
      st_p_sda_rel,
      st_p_final
   } seq_state_t;

   typedef struct packed {
      logic scl;
      logic sda;
   } line_pair_t;

   typedef struct packed {
      seq_state_t st;
      logic [6:0] brg;
      line_pair_t sync1;
      line_pair_t sync2;
      line_pair_t prev;
      logic       enable;
      logic [7:0] ctl2;
      logic [6:0] reload;
      logic       start_seen;
      logic       stop_seen;
      logic       event_flag;
      logic       write_collision_flag;
      logic       bcol;
      logic [7:0] buffer;
      logic       scl_drive;
      logic       sda_drive;
      logic       hold_scl;
      logic [7:0] rdata;
      logic       busy;
   } seq_regs_t;

endpackage

/* verilog/i2c_master_start_stop_sequencer.sv */
// i2c master repeated-start and stop condition sequencer with its register file
// assumes open-drain pads outside, synchronous register port on mclk, byte engine outside
//
// Contract
// - start and stop flags clear on reset/disable
// - event flag on conditions, bytes, acks
// - hardware alone drives and releases lines
// - repeated-start request pulls scl low
// - scl low: load baud, release sda
// - timeout, sda high: release scl, reload
// - sda low one period, clear request
// - start detected sets start-seen status bit
// - repeated-start event after baud timeout
// - repeated start ignored while busy
// - bus collision on sda low or scl fall
// - buffer write in repeated start: collision
// - low five control bits locked while busy
// - scl held low after ninth clock; stop bit
// - stop: sda low, count, release scl, sda
// - stop seen, then clear request, event
// - buffer write during stop: collision
`timescale 1ns/100ps

`include "i2c_seq_consts.svh"

module i2c_master_start_stop_sequencer
   import i2c_seq_pkg::*;
(
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       nrst,
   // register port
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // byte engine, same clock domain
   input  wire logic       byte_done,
   // bus pins, open drain
   input  wire logic       scl_in,
   output logic            scl_out,
   output logic            scl_oe,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   // status
   output logic            serial_event_flag,
   output logic            sequence_busy
);

   seq_regs_t q;
   seq_regs_t d;

   logic scl;
   logic sda;
   logic tmo;
   logic start_det;
   logic stop_det;
   logic ev_set;
   logic wc_set;
   logic bc_set;
   logic rs_clr;
   logic pen_clr;

   function automatic logic baud_done(input logic [6:0] cnt);
      baud_done = (cnt == 7'h00);
   endfunction

   function automatic logic [7:0] status_byte(input logic start_seen, input logic stop_seen);
      logic [7:0] s;
      s = 8'h00;
      s[`BIT_START_SEEN] = start_seen;
      s[`BIT_STOP_SEEN] = stop_seen;
      status_byte = s;
   endfunction

   always_comb begin
      d = q;
      ev_set = 1'b0;
      wc_set = 1'b0;
      bc_set = 1'b0;
      rs_clr = 1'b0;
      pen_clr = 1'b0;

      // two-stage synchronisers; only the second stage is looked at
      d.sync1.scl = scl_in;
      d.sync1.sda = sda_in;
      d.sync2 = q.sync1;
      d.prev = q.sync2;
      scl = q.sync2.scl;
      sda = q.sync2.sda;

      // baud generator free-runs down and parks at zero
      tmo = baud_done(q.brg);
      if (!tmo) begin
         d.brg = q.brg - 7'h01;
      end

      // condition detection on the synchronised lines
      start_det = q.prev.scl & scl & q.prev.sda & ~sda;
      stop_det = q.prev.scl & scl & ~q.prev.sda & sda;
      if (start_det) begin
         d.start_seen = 1'b1;
         d.stop_seen = 1'b0;
      end
      if (stop_det) begin
         d.stop_seen = 1'b1;
         d.start_seen = 1'b0;
      end

      // end of a byte from the engine: event, and scl stays low after the ninth clock
      if (byte_done) begin
         ev_set = 1'b1;
         d.hold_scl = 1'b1;
         d.scl_drive = 1'b1;
      end

      unique case (q.st)
         st_idle: begin
            if (q.enable && q.ctl2[`BIT_REPEATED_START_REQ]) begin
               d.scl_drive = 1'b1;
               d.st = st_rs_scl_low;
            end else if (q.enable && q.ctl2[`BIT_STOP_REQ]) begin
               d.sda_drive = 1'b1;
               d.st = st_p_sda_low;
            end
         end
         st_rs_scl_low: begin
            if (!scl) begin
               d.brg = q.reload;
               d.sda_drive = 1'b0;
               d.st = st_rs_sda_high;
            end
         end
         st_rs_sda_high: begin
            if (tmo) begin
               if (sda) begin
                  d.scl_drive = 1'b0;
                  d.st = st_rs_scl_rel;
               end else begin
                  bc_set = 1'b1;
               end
            end
         end
         st_rs_scl_rel: begin
            if (scl) begin
               if (!sda) begin
                  bc_set = 1'b1;
               end else begin
                  d.brg = q.reload;
                  d.st = st_rs_both_high;
               end
            end
         end
         st_rs_both_high: begin
            if (!scl) begin
               bc_set = 1'b1;
            end else if (tmo) begin
               d.sda_drive = 1'b1;
               d.brg = q.reload;
               d.st = st_rs_sda_low;
            end
         end
         st_rs_sda_low: begin
            // sda is left driven low; baud not reloaded afterwards
            if (tmo) begin
               rs_clr = 1'b1;
               ev_set = 1'b1;
               d.hold_scl = 1'b0;
               d.st = st_idle;
            end
         end
         st_p_sda_low: begin
            if (!sda) begin
               d.brg = q.reload;
               d.st = st_p_count;
            end
         end
         st_p_count: begin
            if (tmo) begin
               d.scl_drive = 1'b0;
               d.hold_scl = 1'b0;
               d.brg = q.reload;
               d.st = st_p_scl_high;
            end
         end
         st_p_scl_high: begin
            if (tmo) begin
               d.sda_drive = 1'b0;
               d.st = st_p_sda_rel;
            end
         end
         st_p_sda_rel: begin
            if (sda && scl) begin
               d.brg = q.reload;
               d.st = st_p_final;
            end
         end
         st_p_final: begin
            if (tmo) begin
               pen_clr = 1'b1;
               ev_set = 1'b1;
               d.st = st_idle;
            end
         end
      endcase

      // collision aborts the sequence and lets go of both lines
      if (bc_set) begin
         d.st = st_idle;
         d.scl_drive = 1'b0;
         d.sda_drive = 1'b0;
         d.hold_scl = 1'b0;
         rs_clr = 1'b1;
         pen_clr = 1'b1;
      end

      // register writes
      if (reg_wr) begin
         unique case (reg_addr)
            `OFS_SERIAL_CONTROL: begin
               d.enable = reg_wdata[`BIT_MODULE_ENABLE];
            end
            `OFS_SERIAL_CONTROL_TWO: begin
               // events are not queued, so requests cannot be stacked mid-sequence
               if (q.busy) begin
                  d.ctl2[7:`CTL2_LOCKED_BITS] = reg_wdata[7:`CTL2_LOCKED_BITS];
               end else begin
                  d.ctl2 = reg_wdata;
               end
            end
            `OFS_BAUD_RELOAD_VALUE: begin
               d.reload = reg_wdata[6:0];
            end
            `OFS_EVENT_REG: begin
               if (reg_wdata[`BIT_SERIAL_EVENT]) begin
                  d.event_flag = 1'b0;
               end
               if (reg_wdata[`BIT_WRITE_COLLISION]) begin
                  d.write_collision_flag = 1'b0;
               end
               if (reg_wdata[`BIT_BUS_COLLISION]) begin
                  d.bcol = 1'b0;
               end
            end
            `OFS_SERIAL_BUFFER: begin
               if (q.busy) begin
                  wc_set = 1'b1;
               end else begin
                  d.buffer = reg_wdata;
               end
            end
            default: begin
            end
         endcase
      end

      // hardware sets win over software clears
      if (ev_set) begin
         d.event_flag = 1'b1;
      end
      if (wc_set) begin
         d.write_collision_flag = 1'b1;
      end
      if (bc_set) begin
         d.bcol = 1'b1;
      end
      if (rs_clr) begin
         d.ctl2[`BIT_REPEATED_START_REQ] = 1'b0;
      end
      if (pen_clr) begin
         d.ctl2[`BIT_STOP_REQ] = 1'b0;
      end

      // disabling the module drops everything back to a released idle bus
      if (!d.enable) begin
         d.st = st_idle;
         d.start_seen = 1'b0;
         d.stop_seen = 1'b0;
         d.scl_drive = 1'b0;
         d.sda_drive = 1'b0;
         d.hold_scl = 1'b0;
         d.ctl2[`BIT_REPEATED_START_REQ] = 1'b0;
         d.ctl2[`BIT_STOP_REQ] = 1'b0;
      end

      d.busy = (d.st != st_idle);

      // read data stands in the cycle after the strobe only
      d.rdata = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            `OFS_SERIAL_CONTROL: begin
               d.rdata[`BIT_MODULE_ENABLE] = q.enable;
            end
            `OFS_SERIAL_CONTROL_TWO: begin
               d.rdata = q.ctl2;
            end
            `OFS_BAUD_RELOAD_VALUE: begin
               d.rdata = {1'b0, q.reload};
            end
            `OFS_SERIAL_STATUS_REG: begin
               d.rdata = status_byte(q.start_seen, q.stop_seen);
            end
            `OFS_EVENT_REG: begin
               d.rdata[`BIT_SERIAL_EVENT] = q.event_flag;
               d.rdata[`BIT_WRITE_COLLISION] = q.write_collision_flag;
               d.rdata[`BIT_BUS_COLLISION] = q.bcol;
            end
            `OFS_SERIAL_BUFFER: begin
               d.rdata = q.buffer;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
         q.st <= st_idle;
         q.sync1 <= 2'b11;
         q.sync2 <= 2'b11;
         q.prev <= 2'b11;
         q.enable <= `RST_MODULE_ENABLE;
         q.ctl2 <= `RST_CONTROL_TWO;
         q.reload <= `RST_BAUD_RELOAD;
         q.buffer <= `RST_BUFFER;
      end else begin
         q <= d;
      end
   end

   // open drain: the pad only ever pulls low
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe = q.scl_drive;
   assign sda_oe = q.sda_drive;
   assign reg_rdata = q.rdata;
   assign serial_event_flag = q.event_flag;
   assign sequence_busy = q.busy;

endmodule

/* bench/i2c_seq_sva.sv */
// assertion checker for the i2c condition sequencer, bound to its top module
// assumes the register offsets of i2c_seq_consts.svh and the single mclk domain
`timescale 1ns/100ps
`include "i2c_seq_consts.svh"
module i2c_seq_sva (
   // clock and reset
   input wire logic       mclk,
   input wire logic       nrst,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   // bus and status
   input wire logic       byte_done,
   input wire logic       scl_in,
   input wire logic       scl_out,
   input wire logic       scl_oe,
   input wire logic       sda_in,
   input wire logic       sda_out,
   input wire logic       sda_oe,
   input wire logic       serial_event_flag,
   input wire logic       sequence_busy
);
   logic       en_q;
   logic [6:0] reload_q;
   logic [7:0] c_scl_q;
   logic [7:0] c_sda_q;
   logic [7:0] lo;
   logic       wr_two;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);
   assign lo = {1'b0, reload_q};
   assign wr_two = reg_wr && reg_addr == `OFS_SERIAL_CONTROL_TWO && en_q && !sequence_busy;
   // counters saturate so a long idle spell cannot wrap into a false match
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         en_q     <= 1'b0;
         reload_q <= 7'h00;
         c_scl_q  <= 8'h00;
         c_sda_q  <= 8'h00;
      end else begin
         if (reg_wr && reg_addr == `OFS_SERIAL_CONTROL) en_q <= reg_wdata[`BIT_MODULE_ENABLE];
         if (reg_wr && reg_addr == `OFS_BAUD_RELOAD_VALUE) reload_q <= reg_wdata[6:0];
         c_scl_q <= $fell(scl_oe) ? 8'h00 : c_scl_q + {7'h00, c_scl_q != 8'hff};
         c_sda_q <= $rose(sda_oe) ? 8'h00 : c_sda_q + {7'h00, c_sda_q != 8'hff};
      end
   end
   chk_rs_scl_low: assert property (wr_two && reg_wdata[1] |-> ##3 scl_oe && sequence_busy)
      else $error("scl not pulled low after repeated start request");
   chk_stop_sda_low: assert property (wr_two && reg_wdata[2:1] == 2'b10 |-> ##3 sda_oe && sequence_busy)
      else $error("sda not pulled low after stop request");
   chk_open_drain: assert property (!scl_out && !sda_out)
      else $error("pin output level not low");
   chk_rs_event: assert property ($fell(sequence_busy) && sda_oe |-> ##[0:1] serial_event_flag)
      else $error("no event after repeated start");
   chk_rs_low_time: assert property ($fell(sequence_busy) && sda_oe |-> c_sda_q >= lo && c_sda_q <= lo + 8'd2)
      else $error("sda low phase length wrong");
   chk_stop_rel_time: assert property ($fell(sda_oe) && sequence_busy && !scl_oe |->
      c_scl_q >= lo && c_scl_q <= lo + 8'd2)
      else $error("sda released at wrong time in stop");
   chk_byte_hold: assert property (byte_done && en_q |-> ##[1:3] scl_oe)
      else $error("scl not held low after byte");
   chk_byte_event: assert property (byte_done && en_q |-> ##[1:3] serial_event_flag)
      else $error("no event after byte");
   chk_off_quiet: assert property (!en_q && !$past(en_q) |-> !sequence_busy && !scl_oe && !sda_oe)
      else $error("activity while disabled");
   cover property ($fell(sequence_busy) && sda_oe);
   cover property ($fell(sda_oe) && sequence_busy && !scl_oe);
   cover property (byte_done && en_q);
endmodule
bind i2c_master_start_stop_sequencer i2c_seq_sva u_i2c_seq_sva (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .byte_done(byte_done),
   .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .serial_event_flag(serial_event_flag), .sequence_busy(sequence_busy));

/* bench/i2c_bus_model.sv */
// open-drain two-wire bus with pull-ups and a far-side device that can hold sda low
// assumes oe high means the master pulls the line low
`timescale 1ns/100ps
module i2c_bus_model (
   // master side
   input  wire logic scl_oe,
   input  wire logic sda_oe,
   // far-side misbehaviour, commanded by the bench
   input  wire logic hold_sda,
   // wire levels
   output logic      scl,
   output logic      sda
);
   // pull-ups win when nobody pulls low, so a released line never keeps an old value
   assign scl = !scl_oe;
   assign sda = !(sda_oe || hold_sda);
endmodule

/* bench/tb_top.sv */
// self-checking bench for the i2c condition sequencer
// assumes the bus model as far side and the bound assertion checker
`timescale 1ns/100ps
`include "i2c_seq_consts.svh"
module tb_top;
   logic       mclk;
   logic       nrst;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_rdata;
   logic       byte_done;
   logic       hold_sda;
   logic       scl;
   logic       sda;
   logic       scl_out;
   logic       scl_oe;
   logic       sda_out;
   logic       sda_oe;
   logic       serial_event_flag;
   logic       sequence_busy;
   int         fail_count;
   int         tests_run;
   i2c_master_start_stop_sequencer u_i2c_master_start_stop_sequencer (.mclk(mclk), .nrst(nrst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .byte_done(byte_done), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .serial_event_flag(serial_event_flag), .sequence_busy(sequence_busy));
   i2c_bus_model u_i2c_bus_model (.scl_oe(scl_oe), .sda_oe(sda_oe), .hold_sda(hold_sda), .scl(scl), .sda(sda));
   always #20 mclk = ~mclk;
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr    <= 1'b0;
   endtask
   task rchk(input logic [3:0] a, input logic [7:0] exp);
      @(posedge mclk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask
   // bounded wait; a hang shows up in the comparisons that follow
   task wait_idle;
      repeat (4) @(posedge mclk);
      for (int n = 0; n < 300 && sequence_busy !== 1'b0; n++) @(posedge mclk);
      #1;
   endtask
   task wrap_up;
      if (fail_count == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #400000;
      fail_count++;
      wrap_up();
   end
   initial begin
      mclk = 1'b0;
      nrst = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      byte_done = 1'b0;
      hold_sda = 1'b0;
      fail_count = 0;
      tests_run = 0;
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      rchk(`OFS_SERIAL_STATUS_REG, 8'h00);
      wr(`OFS_SERIAL_CONTROL, 8'h01);
      wr(`OFS_BAUD_RELOAD_VALUE, 8'h03);
      rchk(`OFS_SERIAL_STATUS_REG, 8'h00);
      wr(`OFS_SERIAL_CONTROL_TWO, 8'h02);
      repeat (4) @(posedge mclk);
      wr(`OFS_SERIAL_BUFFER, 8'ha5);
      wr(`OFS_SERIAL_CONTROL_TWO, 8'h04);
      rchk(`OFS_SERIAL_CONTROL_TWO, 8'h02);
      chk({7'h00, sequence_busy}, 8'h01);
      wait_idle();
      chk({4'h0, sequence_busy, serial_event_flag, scl_oe, sda_oe}, 8'h05);
      rchk(`OFS_SERIAL_STATUS_REG, 8'h08);
      rchk(`OFS_EVENT_REG, 8'h03);
      rchk(`OFS_SERIAL_BUFFER, 8'h00);
      rchk(`OFS_SERIAL_CONTROL_TWO, 8'h00);
      wr(`OFS_EVENT_REG, 8'h07);
      wr(`OFS_SERIAL_BUFFER, 8'ha0);
      rchk(`OFS_SERIAL_BUFFER, 8'ha0);
      @(posedge mclk);
      byte_done <= 1'b1;
      @(posedge mclk);
      byte_done <= 1'b0;
      repeat (3) @(posedge mclk);
      #1;
      chk({7'h00, scl_oe}, 8'h01);
      rchk(`OFS_EVENT_REG, 8'h01);
      wr(`OFS_EVENT_REG, 8'h07);
      wr(`OFS_SERIAL_CONTROL_TWO, 8'h04);
      repeat (4) @(posedge mclk);
      wr(`OFS_SERIAL_BUFFER, 8'h5a);
      wr(`OFS_SERIAL_CONTROL_TWO, 8'h02);
      wait_idle();
      chk({4'h0, sequence_busy, serial_event_flag, scl_oe, sda_oe}, 8'h04);
      rchk(`OFS_SERIAL_STATUS_REG, 8'h10);
      rchk(`OFS_EVENT_REG, 8'h03);
      rchk(`OFS_SERIAL_BUFFER, 8'ha0);
      rchk(`OFS_SERIAL_CONTROL_TWO, 8'h00);
      wr(`OFS_EVENT_REG, 8'h07);
      hold_sda <= 1'b1;
      wr(`OFS_SERIAL_CONTROL_TWO, 8'h02);
      wait_idle();
      chk({4'h0, sequence_busy, serial_event_flag, scl_oe, sda_oe}, 8'h00);
      rchk(`OFS_EVENT_REG, 8'h04);
      rchk(`OFS_SERIAL_CONTROL_TWO, 8'h00);
      hold_sda <= 1'b0;
      wr(`OFS_SERIAL_CONTROL, 8'h00);
      rchk(`OFS_SERIAL_STATUS_REG, 8'h00);
      wrap_up();
   end
endmodule
